// ===== core/ascs_pkg.sv
// Purpose: constants and types of the amplifier software-control sequencer
// Assumes: sys_clk at 40 MHz; the control port is a two-wire serial slave
// Notes: offsets are control port register addresses
`default_nettype none
package ascs_pkg;

  localparam int SYS_CLK_NS      = 25;
  // Longest allowed gap between bit clock edges before a clock fault
  localparam int SCLK_TIMEOUT_NS = 1000;
  localparam int CLK_FAULT_CYC   = SCLK_TIMEOUT_NS / SYS_CLK_NS;
  localparam logic [5:0] CLK_FAULT_LIM = 6'(CLK_FAULT_CYC);

  localparam logic [1:0] SW_MODE_PAT = 2'h3;
  localparam logic [1:0] STRAP_WAIT  = 2'h3;

  localparam logic [7:0] REG_CTRL  = 8'h01;
  localparam logic [7:0] REG_VOL   = 8'h04;
  localparam logic [7:0] REG_MUTE  = 8'h07;
  localparam logic [7:0] REG_FAULT = 8'h08;
  localparam logic [7:0] REG_CLIP2 = 8'h10;
  localparam logic [7:0] REG_CLIP1 = 8'h11;
  localparam logic [7:0] REG_CLIP3 = 8'h12;

  localparam logic [7:0] CTRL_RST  = 8'h01;
  localparam logic [7:0] VOL_RST   = 8'h80;
  localparam logic [7:0] MUTE_RST  = 8'h00;
  localparam logic [1:0] FCFG_RST  = 2'h0;
  localparam logic [7:0] CLIP2_RST = 8'hff;
  localparam logic [7:0] CLIP1_RST = 8'hfc;
  localparam logic [5:0] CLIP3_RST = 6'h3f;

  localparam int CTRL_RUN_BIT  = 0;
  localparam int MUTE_BIT      = 0;
  localparam int FAULT_THR_LSB = 4;
  localparam int FAULT_THR_MSB = 5;
  localparam int FAULT_CLK_BIT = 3;
  localparam int CLIP1_LSB     = 2;
  localparam int CLIP1_MSB     = 7;

  // Synchroniser lanes
  localparam int SY_SCL  = 0;
  localparam int SY_SDA  = 1;
  localparam int SY_SCLK = 2;
  localparam int SY_SDN  = 3;
  localparam int SY_FLT  = 4;
  localparam int SY_GAIN = 7;
  localparam int SY_ADR  = 9;
  localparam int SYNC_W  = 10;

  localparam logic [3:0] I2C_BITS = 4'h8;
  localparam logic [3:0] RD_LAST  = 4'h7;

  typedef enum logic [8:0] {
    I2C_IDLE = 9'h001,
    I2C_ADDR = 9'h002,
    I2C_AACK = 9'h004,
    I2C_PTR  = 9'h008,
    I2C_PACK = 9'h010,
    I2C_WDAT = 9'h020,
    I2C_WACK = 9'h040,
    I2C_RDAT = 9'h080,
    I2C_RACK = 9'h100
  } ascs_i2c_t;

  typedef enum logic [2:0] {
    PWR_SD    = 3'h1,
    PWR_RUN   = 3'h2,
    PWR_FAULT = 3'h4
  } ascs_pwr_t;

endpackage
`default_nettype wire

// ===== core/ascs_sync.sv
// Purpose: two-flop synchroniser for pins from outside the sys_clk domain
// Assumes: each lane is an independent level
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module ascs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Lanes
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] meta;

  for (genvar i = 0; i < W; i++) begin : g_lane
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        meta[i] <= 1'b0;
        q[i]    <= 1'b0;
      end else begin
        meta[i] <= d[i];
        q[i]    <= meta[i];
      end
    end
  end

endmodule
`default_nettype wire

// ===== core/ascs_top.sv
// Purpose: software-control bring-up, shutdown, faults and clipper level
// Assumes: control port is a two-wire serial slave with open-drain data
// Notes: hardware-control mode is not handled; the amplifier stays off
`timescale 1ns/1ps
`default_nettype none
module ascs_top #(
  // Upper six address bits; value is arbitrary
  parameter logic [5:0] DEV_ADDR_HI = 6'h15
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Straps
  input  wire logic [1:0]  gain_select_pins,
  input  wire logic        addr_select_pin,
  // Shutdown pin and audio bit clock
  input  wire logic        amp_shutdown_n,
  input  wire logic        link_bit_clk,
  // Two-wire control port
  input  wire logic        ctl_scl,
  input  wire logic        ctl_sda_in,
  output logic             ctl_sda_out,
  output logic             ctl_sda_oe,
  // Fault detectors
  input  wire logic        overcurrent_det,
  input  wire logic        output_dc_det,
  input  wire logic        overtemp_det,
  // Amplifier controls and status
  output logic             amp_active,
  output logic             amp_mute,
  output logic [19:0]      clip_threshold_level,
  output logic [7:0]       volume_level,
  output logic             overcurrent_fault,
  output logic             output_dc_fault,
  output logic             overtemp_fault,
  output logic             clock_fault
);

  logic [ascs_pkg::SYNC_W-1:0] sy;
  logic [2:0] det;
  logic       sd_pin, scl_s, sda_s, scl_d, sda_d, sclk_d;
  logic       start_c, stop_c, scl_rise, scl_fall, sclk_edge;

  ascs_sync #(.W(ascs_pkg::SYNC_W)) u_sync (
    .clk (sys_clk),
    .rst (rst),
    .d   ({addr_select_pin, gain_select_pins, overtemp_det, output_dc_det,
           overcurrent_det, amp_shutdown_n, link_bit_clk, ctl_sda_in,
           ctl_scl}),
    .q   (sy)
  );

  assign scl_s  = sy[ascs_pkg::SY_SCL];
  assign sda_s  = sy[ascs_pkg::SY_SDA];
  assign sd_pin = sy[ascs_pkg::SY_SDN];
  assign det    = sy[ascs_pkg::SY_FLT +: 3];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      // Match the synchroniser's reset level so no false edge follows
      scl_d  <= 1'b0;
      sda_d  <= 1'b0;
      sclk_d <= 1'b0;
    end else begin
      scl_d  <= scl_s;
      sda_d  <= sda_s;
      sclk_d <= sy[ascs_pkg::SY_SCLK];
    end
  end

  assign start_c   = scl_s && scl_d && sda_d && !sda_s;
  assign stop_c    = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign sclk_edge = sy[ascs_pkg::SY_SCLK] != sclk_d;

  // Straps are caught once, a few cycles after reset release
  logic [1:0] strap_cnt, next_strap_cnt;
  logic       strap_done, next_strap_done, sw_mode, next_sw_mode;
  logic       adr_bit, next_adr_bit;

  always_comb begin
    next_strap_cnt  = strap_cnt;
    next_strap_done = strap_done;
    next_sw_mode    = sw_mode;
    next_adr_bit    = adr_bit;
    if (!strap_done) begin
      next_strap_cnt = strap_cnt + 2'h1;
      if (strap_cnt == ascs_pkg::STRAP_WAIT) begin
        next_strap_done = 1'b1;
        next_sw_mode = sy[ascs_pkg::SY_GAIN +: 2] == ascs_pkg::SW_MODE_PAT;
        next_adr_bit = sy[ascs_pkg::SY_ADR];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
      sw_mode    <= 1'b0;
      adr_bit    <= 1'b0;
    end else begin
      strap_cnt  <= next_strap_cnt;
      strap_done <= next_strap_done;
      sw_mode    <= next_sw_mode;
      adr_bit    <= next_adr_bit;
    end
  end

  // Control port slave
  ascs_pkg::ascs_i2c_t i2c_st, next_i2c_st;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg, reg_ptr, next_reg_ptr, rd_mux;
  logic [7:0] wr_addr, next_wr_addr, wr_data, next_wr_data;
  logic       wr_en, next_wr_en, sda_oe_r, next_sda_oe, rd_ack, next_rd_ack;

  always_comb begin
    next_i2c_st  = i2c_st;
    next_bit_cnt = bit_cnt;
    next_shreg   = shreg;
    next_reg_ptr = reg_ptr;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_en   = 1'b0;
    next_sda_oe  = sda_oe_r;
    next_rd_ack  = rd_ack;
    if (start_c) begin
      next_i2c_st  = ascs_pkg::I2C_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe  = 1'b0;
    end else if (stop_c) begin
      next_i2c_st = ascs_pkg::I2C_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (i2c_st)
        ascs_pkg::I2C_ADDR, ascs_pkg::I2C_PTR, ascs_pkg::I2C_WDAT: begin
          if (scl_rise) begin
            next_shreg   = {shreg[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == ascs_pkg::I2C_BITS) begin
            next_bit_cnt = 4'h0;
            next_sda_oe  = 1'b1;
            if (i2c_st == ascs_pkg::I2C_ADDR) begin
              if (shreg[7:1] == {DEV_ADDR_HI, adr_bit} && sw_mode) begin
                next_i2c_st = ascs_pkg::I2C_AACK;
                next_rd_ack = shreg[0];
              end else begin
                next_i2c_st = ascs_pkg::I2C_IDLE;
                next_sda_oe = 1'b0;
              end
            end else if (i2c_st == ascs_pkg::I2C_PTR) begin
              next_reg_ptr = shreg;
              next_i2c_st  = ascs_pkg::I2C_PACK;
            end else begin
              next_wr_en   = 1'b1;
              next_wr_addr = reg_ptr;
              next_wr_data = shreg;
              next_reg_ptr = reg_ptr + 8'h01;
              next_i2c_st  = ascs_pkg::I2C_WACK;
            end
          end
        end
        ascs_pkg::I2C_AACK: begin
          if (scl_fall) begin
            if (rd_ack) begin
              next_i2c_st = ascs_pkg::I2C_RDAT;
              next_shreg  = rd_mux;
              next_sda_oe = !rd_mux[7];
            end else begin
              next_i2c_st = ascs_pkg::I2C_PTR;
              next_sda_oe = 1'b0;
            end
          end
        end
        ascs_pkg::I2C_PACK, ascs_pkg::I2C_WACK: begin
          if (scl_fall) begin
            next_i2c_st = ascs_pkg::I2C_WDAT;
            next_sda_oe = 1'b0;
          end
        end
        ascs_pkg::I2C_RDAT: begin
          if (scl_fall) begin
            if (bit_cnt == ascs_pkg::RD_LAST) begin
              next_i2c_st  = ascs_pkg::I2C_RACK;
              next_sda_oe  = 1'b0;
              next_bit_cnt = 4'h0;
              next_reg_ptr = reg_ptr + 8'h01;
            end else begin
              next_shreg   = {shreg[6:0], 1'b0};
              next_sda_oe  = !shreg[6];
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end
        end
        ascs_pkg::I2C_RACK: begin
          // Master ack keeps reading; nack ends the transfer
          if (scl_rise) begin
            next_rd_ack = !sda_s;
          end else if (scl_fall) begin
            if (rd_ack) begin
              next_i2c_st = ascs_pkg::I2C_RDAT;
              next_shreg  = rd_mux;
              next_sda_oe = !rd_mux[7];
            end else begin
              next_i2c_st = ascs_pkg::I2C_IDLE;
            end
          end
        end
        default: begin
          next_i2c_st = ascs_pkg::I2C_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      i2c_st   <= ascs_pkg::I2C_IDLE;
      bit_cnt  <= 4'h0;
      shreg    <= 8'h00;
      reg_ptr  <= 8'h00;
      wr_addr  <= 8'h00;
      wr_data  <= 8'h00;
      wr_en    <= 1'b0;
      sda_oe_r <= 1'b0;
      rd_ack   <= 1'b0;
    end else begin
      i2c_st   <= next_i2c_st;
      bit_cnt  <= next_bit_cnt;
      shreg    <= next_shreg;
      reg_ptr  <= next_reg_ptr;
      wr_addr  <= next_wr_addr;
      wr_data  <= next_wr_data;
      wr_en    <= next_wr_en;
      sda_oe_r <= next_sda_oe;
      rd_ack   <= next_rd_ack;
    end
  end

  assign ctl_sda_oe  = sda_oe_r;
  assign ctl_sda_out = 1'b0;

  // Register file; writes land in any power state
  logic [7:0] ctrl, next_ctrl, vol, next_vol, mute, next_mute;
  logic [7:0] clip2, next_clip2, clip1, next_clip1;
  logic [5:0] clip3, next_clip3;
  logic [1:0] fcfg, next_fcfg;
  logic [19:0] thr_stored;

  always_comb begin
    next_ctrl  = ctrl;
    next_vol   = vol;
    next_mute  = mute;
    next_clip2 = clip2;
    next_clip1 = clip1;
    next_clip3 = clip3;
    next_fcfg  = fcfg;
    if (wr_en) begin
      case (wr_addr)
        ascs_pkg::REG_CTRL:  next_ctrl  = wr_data;
        ascs_pkg::REG_VOL:   next_vol   = wr_data;
        ascs_pkg::REG_MUTE:  next_mute  = wr_data;
        ascs_pkg::REG_CLIP2: next_clip2 = wr_data;
        ascs_pkg::REG_CLIP1: next_clip1 = wr_data;
        ascs_pkg::REG_CLIP3: next_clip3 = wr_data[5:0];
        ascs_pkg::REG_FAULT: begin
          next_fcfg = wr_data[ascs_pkg::FAULT_THR_MSB:ascs_pkg::FAULT_THR_LSB];
        end
        default: next_ctrl = ctrl;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl  <= ascs_pkg::CTRL_RST;
      vol   <= ascs_pkg::VOL_RST;
      mute  <= ascs_pkg::MUTE_RST;
      clip2 <= ascs_pkg::CLIP2_RST;
      clip1 <= ascs_pkg::CLIP1_RST;
      clip3 <= ascs_pkg::CLIP3_RST;
      fcfg  <= ascs_pkg::FCFG_RST;
    end else begin
      ctrl  <= next_ctrl;
      vol   <= next_vol;
      mute  <= next_mute;
      clip2 <= next_clip2;
      clip1 <= next_clip1;
      clip3 <= next_clip3;
      fcfg  <= next_fcfg;
    end
  end

  assign thr_stored = {clip3, clip2,
                       clip1[ascs_pkg::CLIP1_MSB:ascs_pkg::CLIP1_LSB]};

  always_comb begin
    case (reg_ptr)
      ascs_pkg::REG_CTRL:  rd_mux = ctrl;
      ascs_pkg::REG_VOL:   rd_mux = vol;
      ascs_pkg::REG_MUTE:  rd_mux = mute;
      ascs_pkg::REG_CLIP2: rd_mux = clip2;
      ascs_pkg::REG_CLIP1: rd_mux = clip1;
      ascs_pkg::REG_CLIP3: rd_mux = {2'h0, clip3};
      ascs_pkg::REG_FAULT: rd_mux = {2'h0, fcfg, clock_fault,
                                     overcurrent_fault, output_dc_fault,
                                     overtemp_fault};
      default:             rd_mux = 8'h00;
    endcase
  end

  // Power sequencing, faults and clock watch
  ascs_pkg::ascs_pwr_t pwr_st, next_pwr_st;
  logic [2:0] flt, next_flt;
  logic [5:0] idle_cnt, next_idle_cnt;
  logic       run_en, next_clk_fault, next_active;
  logic [19:0] next_clip_out;

  always_comb begin
    next_flt = det | (flt & {3{sd_pin}});
    if (sclk_edge) begin
      next_idle_cnt = 6'h00;
    end else if (idle_cnt == ascs_pkg::CLK_FAULT_LIM) begin
      next_idle_cnt = idle_cnt;
    end else begin
      next_idle_cnt = idle_cnt + 6'h01;
    end
    next_clk_fault = next_idle_cnt == ascs_pkg::CLK_FAULT_LIM;
    run_en = sw_mode && sd_pin && ctrl[ascs_pkg::CTRL_RUN_BIT];
    next_pwr_st = pwr_st;
    case (pwr_st)
      ascs_pkg::PWR_SD: begin
        if (run_en && flt == 3'h0) next_pwr_st = ascs_pkg::PWR_RUN;
      end
      ascs_pkg::PWR_RUN: begin
        if (!run_en) next_pwr_st = ascs_pkg::PWR_SD;
        else if (flt != 3'h0) next_pwr_st = ascs_pkg::PWR_FAULT;
      end
      ascs_pkg::PWR_FAULT: begin
        if (!sd_pin) next_pwr_st = ascs_pkg::PWR_SD;
      end
      default: next_pwr_st = ascs_pkg::PWR_SD;
    endcase
    next_active = next_pwr_st == ascs_pkg::PWR_RUN && !next_clk_fault;
    // frozen while running, taken up in shutdown
    if (pwr_st == ascs_pkg::PWR_RUN) begin
      next_clip_out = clip_threshold_level;
    end else begin
      next_clip_out = thr_stored;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwr_st               <= ascs_pkg::PWR_SD;
      flt                  <= 3'h0;
      idle_cnt             <= 6'h00;
      clock_fault          <= 1'b0;
      amp_active           <= 1'b0;
      amp_mute             <= 1'b1;
      clip_threshold_level <= {ascs_pkg::CLIP3_RST, ascs_pkg::CLIP2_RST,
                               ascs_pkg::CLIP1_RST[7:2]};
      volume_level         <= ascs_pkg::VOL_RST;
    end else begin
      pwr_st               <= next_pwr_st;
      flt                  <= next_flt;
      idle_cnt             <= next_idle_cnt;
      clock_fault          <= next_clk_fault;
      amp_active           <= next_active;
      amp_mute             <= mute[ascs_pkg::MUTE_BIT] || !next_active;
      clip_threshold_level <= next_clip_out;
      volume_level         <= vol;
    end
  end

  assign overcurrent_fault = flt[0];
  assign output_dc_fault   = flt[1];
  assign overtemp_fault    = flt[2];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_clip1_wr;
    wr_en && wr_addr == ascs_pkg::REG_CLIP1;
  endsequence
  sequence s_flt_set;
    det[0] ##1 sd_pin;
  endsequence
  sequence s_flt_held;
    overcurrent_fault && sd_pin;
  endsequence

  a_clip_low_store: assert property (
    s_clip1_wr |=> thr_stored[5:0] == $past(wr_data[7:2])
  ) else $error("clip low field not stored");
  a_clip_apply_sd: assert property (
    (pwr_st != ascs_pkg::PWR_RUN) |=> clip_threshold_level == $past(thr_stored)
  ) else $error("threshold not applied in shutdown");
  a_clip_frozen: assert property (
    (pwr_st == ascs_pkg::PWR_RUN) |=> $stable(clip_threshold_level)
  ) else $error("threshold changed while running");
  a_strap_mode: assert property (
    $rose(strap_done) |->
      sw_mode == ($past(sy[ascs_pkg::SY_GAIN +: 2]) == ascs_pkg::SW_MODE_PAT)
  ) else $error("software mode strap wrong");
  a_pin_low_off: assert property (
    !sd_pin |=> !amp_active
  ) else $error("active with shutdown pin low");
  a_bit_clear_off: assert property (
    !ctrl[ascs_pkg::CTRL_RUN_BIT] |=> !amp_active
  ) else $error("active with shutdown bit clear");
  a_fault_set: assert property (
    s_flt_set |-> overcurrent_fault
  ) else $error("fault not latched after detection");
  a_fault_holds: assert property (
    s_flt_held |=> overcurrent_fault
  ) else $error("latched fault lost before toggle");
  a_clk_fault_set: assert property (
    idle_cnt == ascs_pkg::CLK_FAULT_LIM - 6'h01 && !sclk_edge |=> clock_fault
  ) else $error("clock fault not raised");
  a_clk_fault_clear: assert property (
    sclk_edge |=> !clock_fault
  ) else $error("clock fault not cleared");
  a_mute_shutdown: assert property (
    !amp_active |-> amp_mute
  ) else $error("not muted while shut down");

endmodule
`default_nettype wire

// ===== verif/ascs_host.sv
// Purpose: host model driving the two-wire control port and the bit clock
// Assumes: SDA is pulled up; host and device only ever pull it low
// Notes: SCL half period is 8 sys_clk, twice the device minimum
`timescale 1ns/1ps
`default_nettype none
module ascs_host #(
  parameter logic [6:0] ADDR = 7'h2b
) (
  // Clock
  input  wire logic sys_clk,
  // Control port
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_pull,
  // Audio bit clock
  output var  logic bclk
);
  logic clk_on;
  logic ack_ok;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    bclk = 1'b0;
    clk_on = 1'b0;
    ack_ok = 1'b1;
  end

  // Free of sys_clk phase; parked low while stopped
  always begin
    #100;
    bclk = clk_on ? ~bclk : 1'b0;
  end

  // One SCL period; SDA only moves while SCL is low
  task automatic bit_io(input logic b, output logic r);
    scl <= 1'b0;
    repeat (4) @(posedge sys_clk);
    sda_pull <= ~b;
    repeat (4) @(posedge sys_clk);
    scl <= 1'b1;
    repeat (8) @(posedge sys_clk);
    r = sda;
  endtask

  // Ack slot is always released: reads are single byte, ended by nack
  task automatic byte_io(input logic [7:0] tx, input logic chk,
                         output logic [7:0] rx);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(1'b1, r);
    if (chk && r !== 1'b0) ack_ok = 1'b0;
  endtask

  task automatic start();
    logic r;
    bit_io(1'b1, r);
    sda_pull <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic stop();
    logic r;
    bit_io(1'b0, r);
    sda_pull <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] x;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, x);
    byte_io(ptr, 1'b1, x);
    byte_io(d, 1'b1, x);
    stop();
  endtask

  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] x;
    start();
    byte_io({ADDR, 1'b0}, 1'b1, x);
    byte_io(ptr, 1'b1, x);
    start();
    byte_io({ADDR, 1'b1}, 1'b1, x);
    byte_io(8'hff, 1'b0, d);
    stop();
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: self-checking bench for the software-control sequencer
// Assumes: host model owns SCL, SDA and bit clock; bench owns pins
// Notes: straps held stable across every reset release
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [5:0] ADR_HI = 6'h15;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [1:0]  gain = 2'h3;
  logic        sd_n = 1'b0;
  logic        adr_sel = 1'b1;
  logic [2:0]  det = 3'h0;
  logic        scl, sda_pull, bclk, sda_oe, sda_out, active, mute;
  logic        oc_f, dc_f, ot_f, clk_f;
  logic [19:0] clip;
  logic [7:0]  vol, rv;
  wire  logic  sda;
  int          failures = 0;
  int          num_checks = 0;

  assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
  always #12.5 sys_clk = ~sys_clk;

  ascs_top #(.DEV_ADDR_HI(ADR_HI)) ascs_top_inst (
    .sys_clk(sys_clk), .rst(rst), .gain_select_pins(gain),
    .addr_select_pin(adr_sel), .amp_shutdown_n(sd_n), .link_bit_clk(bclk),
    .ctl_scl(scl), .ctl_sda_in(sda), .ctl_sda_out(sda_out),
    .ctl_sda_oe(sda_oe), .overcurrent_det(det[2]),
    .output_dc_det(det[1]), .overtemp_det(det[0]), .amp_active(active),
    .amp_mute(mute), .clip_threshold_level(clip), .volume_level(vol),
    .overcurrent_fault(oc_f), .output_dc_fault(dc_f),
    .overtemp_fault(ot_f), .clock_fault(clk_f));

  ascs_host #(.ADDR({ADR_HI, 1'b1})) ascs_host_inst (
    .sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull),
    .bclk(bclk));

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic summarize();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic t_reset();
    chk({active, mute, oc_f, dc_f, ot_f}, 20'h08);
    chk(clip, 20'hfffff);
    chk(vol, 20'h80);
    ascs_host_inst.rd(8'h11, rv);
    chk(rv, 20'hfc);
    ascs_host_inst.rd(8'h20, rv);
    chk(rv, 20'h00);
  endtask

  // Power-up order: clocks, program and mute, release, unmute
  task automatic t_bringup();
    ascs_host_inst.clk_on <= 1'b1;
    ascs_host_inst.wr(8'h12, 8'h2a);
    ascs_host_inst.wr(8'h10, 8'h5c);
    ascs_host_inst.wr(8'h11, 8'hb4);
    ascs_host_inst.wr(8'h07, 8'h01);
    cyc(4);
    chk(clip, {6'h2a, 8'h5c, 6'h2d});
    chk(active, 1'b0);
    ascs_host_inst.rd(8'h11, rv);
    chk(rv, 20'hb4);
    sd_n <= 1'b1;
    cyc(10);
    chk({active, mute, clk_f}, 20'h6);
    ascs_host_inst.wr(8'h07, 8'h00);
    cyc(4);
    chk(mute, 1'b0);
    chk(ascs_host_inst.ack_ok, 1'b1);
  endtask

  task automatic t_running();
    ascs_host_inst.wr(8'h04, 8'h33);
    cyc(4);
    chk(vol, 20'h33);
    ascs_host_inst.wr(8'h11, 8'h00);
    cyc(4);
    chk(clip, {6'h2a, 8'h5c, 6'h2d});
    ascs_host_inst.wr(8'h01, 8'h00);
    cyc(4);
    chk({active, mute}, 20'h1);
    chk(clip, {6'h2a, 8'h5c, 6'h00});
    ascs_host_inst.wr(8'h01, 8'h01);
    cyc(10);
    chk({active, mute}, 20'h2);
  endtask

  task automatic t_clock_fault();
    ascs_host_inst.clk_on <= 1'b0;
    cyc(60);
    chk({clk_f, active}, 20'h2);
    ascs_host_inst.rd(8'h08, rv);
    chk(rv & 8'h08, 20'h08);
    ascs_host_inst.clk_on <= 1'b1;
    cyc(20);
    chk({clk_f, active}, 20'h1);
  endtask

  // Each latched fault holds until the shutdown pin toggles
  task automatic t_latched();
    for (int i = 0; i < 3; i++) begin
      det <= 3'h1 << i;
      cyc(5);
      det <= 3'h0;
      cyc(10);
      chk({oc_f, dc_f, ot_f}, 20'h1 << i);
      chk(active, 1'b0);
      ascs_host_inst.rd(8'h08, rv);
      chk(rv & 8'h07, 20'h1 << i);
      sd_n <= 1'b0;
      cyc(10);
      chk({oc_f, dc_f, ot_f}, 20'h0);
      sd_n <= 1'b1;
      cyc(10);
      chk(active, 1'b1);
    end
  endtask

  task automatic t_shutdown();
    ascs_host_inst.wr(8'h07, 8'h01);
    cyc(4);
    chk(mute, 1'b1);
    sd_n <= 1'b0;
    cyc(6);
    chk(active, 1'b0);
    ascs_host_inst.wr(8'h08, 8'h30);
    ascs_host_inst.rd(8'h08, rv);
    chk(rv & 8'h30, 20'h30);
    ascs_host_inst.clk_on <= 1'b0;
  endtask

  // Other address strap, then gain straps at 01: port stays deaf
  task automatic t_hw_mode();
    for (int i = 0; i < 2; i++) begin
      gain    <= (i == 0) ? 2'h3 : 2'h1;
      adr_sel <= (i != 0);
      rst     <= 1'b1;
      cyc(10);
      rst <= 1'b0;
      cyc(20);
      ascs_host_inst.ack_ok = 1'b1;
      ascs_host_inst.rd(8'h07, rv);
      chk(ascs_host_inst.ack_ok, 1'b0);
    end
    ascs_host_inst.clk_on <= 1'b1;
    sd_n <= 1'b1;
    cyc(20);
    chk(active, 1'b0);
  endtask

  initial begin
    cyc(10);
    rst <= 1'b0;
    cyc(10);
    t_reset();
    t_bringup();
    t_running();
    t_clock_fault();
    t_latched();
    t_shutdown();
    t_hw_mode();
    summarize();
  end

  // Run needs about 12000 cycles; allow five times that
  initial begin
    #1500000;
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
